// ==== dv/lsr_ram_model.sv ====
// Behavioural model of the latched-address static RAM
`timescale 1ns/10ps
`include "lsr_consts.svh"
module lsr_ram_model #(
  parameter int AW = 10,
  parameter int DW = 4
) (
  // Pins from the controller
  input  wire lsr_pkg::lsr_ctrl_s i_ctrl,
  input  wire logic [AW-1:0]      i_addr,
  input  wire logic [DW-1:0]      i_dq_host,
  input  wire logic               i_dq_oe_n,
  // Resolved data pin
  output logic [DW-1:0]           o_dq
);
  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] lat;
  logic [DW-1:0] hold;
  logic [DW-1:0] last = '0;
  logic          acc = 1'h0;
  wire logic sel = !i_ctrl.select_one_n && !i_ctrl.select_two_n;
  wire logic wint = !i_ctrl.enable_n && sel && !i_ctrl.write_n;
  wire logic drv = sel && i_ctrl.write_n;
  wire logic [DW-1:0] cur = acc ? mem[lat] : ~mem[lat];
  wire logic [DW-1:0] dval = !i_ctrl.enable_n ? cur : hold;
  // Address latch; data is wrong until the access delay runs out
  always @(negedge i_ctrl.enable_n) begin
    lat = i_addr;
    acc = 1'h0;
    #(`LSR_ENABLE_ACCESS_NS) acc = !i_ctrl.enable_n;
  end
  // Output latch on enable rise
  always @(posedge i_ctrl.enable_n) hold = cur;
  // Store when the write interval closes; undriven pin stores junk
  always @(negedge wint) begin
    mem[lat] = i_dq_oe_n ? ~i_dq_host : i_dq_host;
  end
  // Pin level; contention of unequal values gives unknown
  always @* begin
    if (!i_dq_oe_n && drv)
      o_dq = (i_dq_host === dval) ? dval : 'x;
    else if (!i_dq_oe_n)
      o_dq = i_dq_host;
    else if (drv)
      o_dq = dval;
    else
      o_dq = ~last;
  end
  // Last driven value, inverted when released
  always @* begin
    if (!i_dq_oe_n)
      last = i_dq_host;
    else if (drv)
      last = dval;
  end
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the latched static RAM controller
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic       w;
    logic       m;
    logic [9:0] a;
    logic [3:0] d;
    logic [3:0] e;
  } lsr_row_s;
  logic               clk = 1'h0;
  logic               rst_b = 1'h0;
  logic               valid = 1'h0;
  logic               write = 1'h0;
  logic               rmw = 1'h0;
  logic [9:0]         addr = '0;
  logic [3:0]         wdata = '0;
  logic               ready;
  logic               rsp;
  logic               oe_n;
  logic [3:0]         rdata;
  logic [3:0]         dq_out;
  logic [3:0]         dq;
  logic [9:0]         maddr;
  lsr_pkg::lsr_ctrl_s ctrl;
  int                 miscompares = 0;
  int                 checks = 0;
  lsr_row_s           rows [6] = '{
    '{1'h1, 1'h0, 10'h000, 4'h5, 4'h0},
    '{1'h1, 1'h0, 10'h3FF, 4'hA, 4'h0},
    '{1'h0, 1'h0, 10'h000, 4'h0, 4'h5},
    '{1'h0, 1'h0, 10'h3FF, 4'h0, 4'hA},
    '{1'h1, 1'h1, 10'h3FF, 4'h3, 4'hA},
    '{1'h0, 1'h0, 10'h3FF, 4'h0, 4'h3}};
  // Clock, 50 ns period
  initial forever #25 clk = ~clk;
  lsr_host dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_req_valid(valid),
    .i_req_write(write), .i_req_rmw(rmw), .i_req_addr(addr),
    .i_req_wdata(wdata), .o_req_ready(ready), .o_rsp_valid(rsp),
    .o_rsp_rdata(rdata), .o_mem_ctrl(ctrl), .o_mem_addr(maddr),
    .o_mem_dq_out(dq_out), .o_mem_dq_oe_n(oe_n), .i_mem_dq_in(dq));
  lsr_ram_model ram (.i_ctrl(ctrl), .i_addr(maddr), .i_dq_host(dq_out),
    .i_dq_oe_n(oe_n), .o_dq(dq));
  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // Bounded wait for a flag
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'h1) begin
      @(posedge clk);
      n++;
      if (n > 100) begin
        miscompares++;
        summarize();
      end
    end
  endtask
  // One request, response check, idle pins afterwards
  task automatic run(input lsr_row_s r);
    @(posedge clk);
    wait_hi(ready);
    valid <= 1'h1;
    write <= r.w;
    rmw <= r.m;
    addr <= r.a;
    wdata <= r.d;
    @(posedge clk);
    valid <= 1'h0;
    @(posedge clk);
    wait_hi(rsp);
    if (!r.w || r.m)
      cmp(rdata, r.e);
    @(posedge clk);
    wait_hi(ready);
    cmp(ctrl, 4'hF);
    cmp({3'h0, oe_n}, 4'h1);
    cmp(maddr[3:0], r.a[3:0]);
    if (r.w)
      cmp(dq_out, r.d);
  endtask
  // Reset, table rows, then a refused request
  initial begin
    repeat (20) @(posedge clk);
    cmp(ctrl, 4'hF);
    cmp({3'h0, ready}, 4'h1);
    rst_b <= 1'h1;
    foreach (rows[i]) run(rows[i]);
    fork
      run('{1'h0, 1'h0, 10'h000, 4'h0, 4'h5});
      begin
        repeat (4) @(posedge clk);
        valid <= 1'h1;
        write <= 1'h1;
        addr <= 10'h000;
        wdata <= 4'hF;
        @(posedge clk);
        valid <= 1'h0;
      end
    join
    run('{1'h0, 1'h0, 10'h000, 4'h0, 4'h5});
    // Reset in mid-read returns pins to idle, then a clean read
    valid <= 1'h1;
    write <= 1'h0;
    addr <= 10'h3FF;
    @(posedge clk);
    valid <= 1'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    cmp(ctrl, 4'hF);
    cmp({3'h0, oe_n}, 4'h1);
    rst_b <= 1'h1;
    run('{1'h0, 1'h0, 10'h3FF, 4'h0, 4'h3});
    summarize();
  end
endmodule

// ==== hw/lsr_consts.svh ====
// Timing constants for the latched static RAM cycle controller
//==================================================================
// Operation
// - Hold address stable past chip enable fall
// - Read needs enable, selects low, strobe high
// - Meet data setup and hold at write end
// - Selects first: wait disable delay before driving
// - Selects first: strobe width disable plus setup
// - Consecutive writes may keep strobe low
`ifndef LSR_CONSTS_SVH
`define LSR_CONSTS_SVH
`define LSR_CLK_PERIOD_NS      50
`define LSR_ENABLE_ACCESS_NS   300
`define LSR_WR_DISABLE_NS      30
`define LSR_DATA_SETUP_NS      150
`define LSR_DATA_HOLD_NS       0
`define LSR_MIN_WRITE_NS       180
`define LSR_SEL_DISABLE_NS     150
`define LSR_ADDR_HOLD_NS       50
`define LSR_EN_HIGH_NS         100
`define LSR_CEIL(t) (((t) + `LSR_CLK_PERIOD_NS - 1) / `LSR_CLK_PERIOD_NS)
`define LSR_MAX1(n) (((n) < 1) ? 1 : (n))
`define LSR_ACCESS_CYC  `LSR_MAX1(`LSR_CEIL(`LSR_ENABLE_ACCESS_NS))
`define LSR_WRDIS_CYC   `LSR_MAX1(`LSR_CEIL(`LSR_WR_DISABLE_NS))
`define LSR_SETUP_CYC   `LSR_MAX1(`LSR_CEIL(`LSR_DATA_SETUP_NS))
`define LSR_HOLD_CYC    `LSR_MAX1(`LSR_CEIL(`LSR_DATA_HOLD_NS))
`define LSR_MINWR_CYC   `LSR_MAX1(`LSR_CEIL(`LSR_MIN_WRITE_NS))
`define LSR_SELDIS_CYC  `LSR_MAX1(`LSR_CEIL(`LSR_SEL_DISABLE_NS))
`define LSR_AHOLD_CYC   `LSR_MAX1(`LSR_CEIL(`LSR_ADDR_HOLD_NS))
`define LSR_ENHI_CYC    `LSR_MAX1(`LSR_CEIL(`LSR_EN_HIGH_NS))
`endif

// ==== hw/lsr_host.sv ====
// Host-side cycle controller for a latched-address static RAM
`timescale 1ns/10ps
`include "lsr_consts.svh"
module lsr_host #(
  parameter int AW = 10,
  parameter int DW = 4
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_b,
  // User request side
  input  wire logic          i_req_valid,
  input  wire logic          i_req_write,
  input  wire logic          i_req_rmw,
  input  wire logic [AW-1:0] i_req_addr,
  input  wire logic [DW-1:0] i_req_wdata,
  output logic               o_req_ready,
  output logic               o_rsp_valid,
  output logic [DW-1:0]      o_rsp_rdata,
  // Memory pins
  output lsr_pkg::lsr_ctrl_s o_mem_ctrl,
  output logic [AW-1:0]      o_mem_addr,
  output logic [DW-1:0]      o_mem_dq_out,
  output logic               o_mem_dq_oe_n,
  input  wire logic [DW-1:0] i_mem_dq_in
);
  localparam logic [3:0] ACC_C  = 4'(`LSR_ACCESS_CYC);
  localparam logic [3:0] WDIS_C = 4'(`LSR_WRDIS_CYC);
  localparam logic [3:0] SET_C  = 4'(`LSR_SETUP_CYC);
  localparam logic [3:0] HOLD_C = 4'(`LSR_HOLD_CYC);
  localparam logic [3:0] AH_C   = 4'(`LSR_AHOLD_CYC);
  localparam logic [3:0] ENH_C  = 4'(`LSR_ENHI_CYC);
  localparam logic [3:0] SDIS_C = 4'(`LSR_SELDIS_CYC);
  localparam logic [3:0] MINW_C = 4'(`LSR_MINWR_CYC);

  //==================================================================
  // State and registers
  lsr_pkg::lsr_state_e state_reg, state_next;
  logic [3:0]    cnt_reg, cnt_next;
  logic          wr_reg, rmw_reg, rd_done_reg;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] wdata_reg;
  logic          en_n_reg, sel_n_reg, wr_n_reg, oe_n_reg;
  logic [3:0]    wlow_reg;

  // Decodes
  wire cnt_done = (cnt_reg == 4'h1);
  wire take     = (state_reg == lsr_pkg::ST_IDLE) && i_req_valid;
  wire rd_phase = (state_reg == lsr_pkg::ST_ACCESS);
  assign o_req_ready = (state_reg == lsr_pkg::ST_IDLE);

  // Next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg > 4'h1) ? cnt_reg - 4'h1 : cnt_reg;
    case (state_reg)
      lsr_pkg::ST_IDLE: begin
        if (i_req_valid) begin
          state_next = lsr_pkg::ST_AHOLD;
          cnt_next   = AH_C;
        end
      end
      lsr_pkg::ST_AHOLD: begin
        if (cnt_done) begin
          if (!wr_reg || rmw_reg) begin
            state_next = lsr_pkg::ST_ACCESS;
            cnt_next   = ACC_C + 4'h1; // Margin past access
          end else begin
            state_next = lsr_pkg::ST_WSETUP;
            cnt_next   = SET_C;
          end
        end
      end
      lsr_pkg::ST_ACCESS: begin
        if (cnt_done) begin
          if (rmw_reg) begin
            state_next = lsr_pkg::ST_WDIS;
            cnt_next   = WDIS_C;
          end else begin
            state_next = lsr_pkg::ST_RECOV;
            cnt_next   = ENH_C;
          end
        end
      end
      lsr_pkg::ST_WDIS: begin
        if (cnt_done) begin
          state_next = lsr_pkg::ST_WSETUP;
          cnt_next   = SET_C;
        end
      end
      lsr_pkg::ST_WSETUP: begin
        if (cnt_done && wlow_reg >= MINW_C) begin
          state_next = lsr_pkg::ST_WHOLD;
          cnt_next   = HOLD_C;
        end
      end
      lsr_pkg::ST_WHOLD: begin
        if (cnt_done) begin
          state_next = lsr_pkg::ST_SDIS;
          cnt_next   = SDIS_C;
        end
      end
      lsr_pkg::ST_SDIS: begin
        if (cnt_done) begin
          state_next = lsr_pkg::ST_RECOV;
          cnt_next   = ENH_C;
        end
      end
      lsr_pkg::ST_RECOV: begin
        if (cnt_done) begin
          state_next = lsr_pkg::ST_IDLE;
        end
      end
      default: state_next = lsr_pkg::ST_IDLE;
    endcase
  end

  // Pin levels per state
  // Enable falls one cycle after the address settles
  wire en_n_next  = !(state_next != lsr_pkg::ST_IDLE &&
                      state_next != lsr_pkg::ST_AHOLD &&
                      state_next != lsr_pkg::ST_RECOV);
  // Selects rise with the strobe: device never drives onto host data
  wire sel_n_next = !(state_next == lsr_pkg::ST_ACCESS ||
                      state_next == lsr_pkg::ST_WDIS ||
                      state_next == lsr_pkg::ST_WSETUP);
  wire wr_n_next  = !(state_next == lsr_pkg::ST_WDIS ||
                      state_next == lsr_pkg::ST_WSETUP);
  wire oe_n_next  = !(state_next == lsr_pkg::ST_WSETUP ||
                      state_next == lsr_pkg::ST_WHOLD);

  // Sequential update
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_reg <= lsr_pkg::ST_IDLE;
      cnt_reg   <= 4'h0;
      en_n_reg  <= 1'b1;
      sel_n_reg <= 1'b1;
      wr_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      wlow_reg  <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      en_n_reg  <= en_n_next;
      sel_n_reg <= sel_n_next;
      wr_n_reg  <= wr_n_next;
      oe_n_reg  <= oe_n_next;
      wlow_reg  <= wr_n_next ? 4'h0 : wlow_reg + {3'h0, wlow_reg != 4'hf};
    end
  end

  // Request capture and read data
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      wr_reg      <= 1'b0;
      rmw_reg     <= 1'b0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      o_rsp_rdata <= '0;
      rd_done_reg <= 1'b0;
    end else begin
      rd_done_reg <= 1'b0;
      if (take) begin
        wr_reg    <= i_req_write;
        rmw_reg   <= i_req_write && i_req_rmw;
        addr_reg  <= i_req_addr;
        wdata_reg <= i_req_wdata;
      end
      if (rd_phase && cnt_done) begin
        o_rsp_rdata <= i_mem_dq_in;
        rd_done_reg <= 1'b1;
      end
      if (state_reg == lsr_pkg::ST_RECOV && cnt_done && wr_reg) begin
        rd_done_reg <= 1'b1;
      end
    end
  end

  // Outputs
  assign o_rsp_valid             = rd_done_reg;
  assign o_mem_ctrl.enable_n     = en_n_reg;
  assign o_mem_ctrl.select_one_n = sel_n_reg;
  assign o_mem_ctrl.select_two_n = sel_n_reg;
  assign o_mem_ctrl.write_n      = wr_n_reg;
  assign o_mem_addr              = addr_reg;
  assign o_mem_dq_out            = wdata_reg;
  assign o_mem_dq_oe_n           = oe_n_reg;

  //==================================================================
  // Checks
  no_drive_sel_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (!o_mem_dq_oe_n && !sel_n_reg && $past(o_mem_dq_oe_n)) |->
      !wr_n_reg && ($past(wr_n_reg) == 1'b0 || $past(sel_n_reg) == 1'b1))
    else $error("Host drives data while device may drive");
  write_low_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    !wr_n_reg |-> !en_n_reg && !o_mem_dq_oe_n || state_reg ==
      lsr_pkg::ST_WDIS)
    else $error("Write strobe low outside enable");
  setup_end_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    $rose(wr_n_reg) |-> $past(o_mem_dq_oe_n, 1) == 1'b0 &&
      $past(o_mem_dq_oe_n, 3) == 1'b0 && !o_mem_dq_oe_n)
    else $error("Data not held around write end");
  min_pulse_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    $fell(wr_n_reg) |-> !wr_n_reg [*4])
    else $error("Write strobe too short");
  addr_hold_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    !en_n_reg |-> $stable(o_mem_addr))
    else $error("Address moved within cycle");
  access_wait_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    $fell(en_n_reg) && !wr_reg |-> ##[6:9] o_rsp_valid)
    else $error("Read response timing wrong");
  enable_high_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    $rose(en_n_reg) |-> en_n_reg [*2])
    else $error("Enable high time too short");
  sel_first_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    $fell(sel_n_reg) && wr_reg && !rmw_reg |-> !wr_n_reg)
    else $error("Plain write selects before strobe");
endmodule

// ==== hw/lsr_pkg.sv ====
// Types for the latched static RAM cycle controller
package lsr_pkg;
  // Controller states, Gray coded in declaration order
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_AHOLD  = 4'h1,
    ST_ACCESS = 4'h3,
    ST_WDIS   = 4'h2,
    ST_WSETUP = 4'h6,
    ST_WHOLD  = 4'h7,
    ST_RECOV  = 4'h5,
    ST_SDIS   = 4'h4
  } lsr_state_e;
  // Pins driven towards the memory
  typedef struct packed {
    logic enable_n;
    logic select_one_n;
    logic select_two_n;
    logic write_n;
  } lsr_ctrl_s;
endpackage
